// [core/dag_address_generator.sv]
// DMA channel address generator: per-port address update after each element
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module dag_address_generator #(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Sequencer side
    input wire dag_pkg::dag_config_type cfg,
    input wire dag_pkg::dag_event_type evt,
    // Addresses to the ports
    output logic [ADDR_W-1:0] src_addr,
    output logic [ADDR_W-1:0] dest_addr
);

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] channel_control_ff;
    logic index_register_select_ff;
    logic [ADDR_W-1:0] src_start_ff;
    logic [ADDR_W-1:0] dst_start_ff;
    logic [ADDR_W-1:0] src_addr_ff;
    logic [ADDR_W-1:0] dst_addr_ff;
    logic [15:0] reg_rdata_ff;
    logic [ADDR_W-1:0] nxt_src_addr;
    logic [ADDR_W-1:0] nxt_dst_addr;

    // Sign-extend a 16-bit index so negative strides walk backwards
    function automatic logic [ADDR_W-1:0] sext(input logic [15:0] v);
        sext = ADDR_W'({{(32 - 16){v[15]}}, v});
    endfunction

    // Step for one port, shared by both ports
    function automatic logic [ADDR_W-1:0] step_of(
        input logic [1:0] mode,
        input dag_pkg::dag_data_type dt,
        input logic [15:0] elem,
        input logic [15:0] frame,
        input logic last
    );
        logic [ADDR_W-1:0] s;
        s = '0;
        unique case (mode)
            dag_pkg::MODE_CONSTANT: s = '0;
            dag_pkg::MODE_POST_INC: begin
                unique case (dt)
                    dag_pkg::DATA_8BIT: s = ADDR_W'(dag_pkg::STEP_8BIT);
                    dag_pkg::DATA_16BIT: s = ADDR_W'(dag_pkg::STEP_16BIT);
                    dag_pkg::DATA_32BIT: s = ADDR_W'(dag_pkg::STEP_32BIT);
                    default: s = ADDR_W'(dag_pkg::STEP_8BIT);
                endcase
            end
            dag_pkg::MODE_SINGLE_INDEX: s = sext(elem);
            dag_pkg::MODE_DOUBLE_INDEX: s = last ? sext(frame) : sext(elem);
        endcase
        step_of = s;
    endfunction

    // ****************************************
    // Register writes
    // ****************************************
    // Bit 10 is stored as written; keeping it zero is software's job
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            channel_control_ff <= dag_pkg::CHANNEL_CONTROL_RESET;
            index_register_select_ff <= 1'b0;
            src_start_ff <= ADDR_W'(dag_pkg::ADDR_RESET);
            dst_start_ff <= ADDR_W'(dag_pkg::ADDR_RESET);
        end else if (reg_wr) begin
            unique case (reg_addr)
                dag_pkg::ADDR_CHANNEL_CONTROL: channel_control_ff <= reg_wdata;
                dag_pkg::ADDR_INDEX_SELECT: index_register_select_ff <= reg_wdata[0];
                dag_pkg::ADDR_SRC_START_LO: src_start_ff[15:0] <= reg_wdata;
                dag_pkg::ADDR_SRC_START_HI: src_start_ff[ADDR_W-1:16] <= reg_wdata[ADDR_W-17:0];
                dag_pkg::ADDR_DST_START_LO: dst_start_ff[15:0] <= reg_wdata;
                dag_pkg::ADDR_DST_START_HI: dst_start_ff[ADDR_W-1:16] <= reg_wdata[ADDR_W-17:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Next addresses
    // ****************************************
    logic [1:0] dest_addr_update_mode;
    logic [1:0] src_addr_update_mode;
    logic [15:0] dest_element_step;
    logic [15:0] dest_frame_step;

    assign dest_addr_update_mode = channel_control_ff[dag_pkg::DEST_MODE_LSB +: 2];
    assign src_addr_update_mode = channel_control_ff[dag_pkg::SRC_MODE_LSB +: 2];
    // Shared mode reuses the source indexes for the write side
    assign dest_element_step = index_register_select_ff ? cfg.dest_element_step
                                                        : cfg.src_element_step;
    assign dest_frame_step = index_register_select_ff ? cfg.dest_frame_step
                                                      : cfg.src_frame_step;

    always_comb begin
        nxt_src_addr = src_addr_ff + step_of(src_addr_update_mode, cfg.data_type,
            cfg.src_element_step, cfg.src_frame_step, evt.last_in_frame);
        nxt_dst_addr = dst_addr_ff + step_of(dest_addr_update_mode, cfg.data_type,
            dest_element_step, dest_frame_step, evt.last_in_frame);
    end

    // Address registers show the element about to move until the strobe, so at the
    // end of a transfer they hold the address one step past the last element
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_addr_ff <= ADDR_W'(dag_pkg::ADDR_RESET);
            dst_addr_ff <= ADDR_W'(dag_pkg::ADDR_RESET);
        end else if (evt.load_start) begin
            src_addr_ff <= src_start_ff;
            dst_addr_ff <= dst_start_ff;
        end else if (evt.element_done) begin
            src_addr_ff <= nxt_src_addr;
            dst_addr_ff <= nxt_dst_addr;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= dag_pkg::READ_UNMAPPED;
        end else if (reg_rd) begin
            unique case (reg_addr)
                dag_pkg::ADDR_CHANNEL_CONTROL: reg_rdata_ff <= channel_control_ff;
                dag_pkg::ADDR_INDEX_SELECT: reg_rdata_ff <= {15'h0000, index_register_select_ff};
                dag_pkg::ADDR_SRC_START_LO: reg_rdata_ff <= src_start_ff[15:0];
                dag_pkg::ADDR_SRC_START_HI: reg_rdata_ff <= src_start_ff[31:16];
                dag_pkg::ADDR_DST_START_LO: reg_rdata_ff <= dst_start_ff[15:0];
                dag_pkg::ADDR_DST_START_HI: reg_rdata_ff <= dst_start_ff[31:16];
                dag_pkg::ADDR_SRC_NOW_LO: reg_rdata_ff <= src_addr_ff[15:0];
                dag_pkg::ADDR_SRC_NOW_HI: reg_rdata_ff <= src_addr_ff[31:16];
                dag_pkg::ADDR_DST_NOW_LO: reg_rdata_ff <= dst_addr_ff[15:0];
                dag_pkg::ADDR_DST_NOW_HI: reg_rdata_ff <= dst_addr_ff[31:16];
                default: reg_rdata_ff <= dag_pkg::READ_UNMAPPED;
            endcase
        end else begin
            reg_rdata_ff <= dag_pkg::READ_UNMAPPED;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign src_addr = src_addr_ff;
    assign dest_addr = dst_addr_ff;

endmodule

`default_nettype wire

// [inc/dag_pkg.sv]
// Package for the DMA channel address generator: offsets, fields, modes and carriers
package dag_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_CHANNEL_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_INDEX_SELECT = 4'h1;
    localparam logic [3:0] ADDR_SRC_START_LO = 4'h2;
    localparam logic [3:0] ADDR_SRC_START_HI = 4'h3;
    localparam logic [3:0] ADDR_DST_START_LO = 4'h4;
    localparam logic [3:0] ADDR_DST_START_HI = 4'h5;
    localparam logic [3:0] ADDR_SRC_NOW_LO = 4'h6;
    localparam logic [3:0] ADDR_SRC_NOW_HI = 4'h7;
    localparam logic [3:0] ADDR_DST_NOW_LO = 4'h8;
    localparam logic [3:0] ADDR_DST_NOW_HI = 4'h9;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int DEST_MODE_LSB = 14;
    localparam int SRC_MODE_LSB = 12;
    localparam int KEEP_ZERO_BIT = 10;
    localparam logic [15:0] CHANNEL_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

    // ****************************************
    // Step sizes per data type
    // ****************************************
    localparam logic [31:0] STEP_8BIT = 32'h0000_0001;
    localparam logic [31:0] STEP_16BIT = 32'h0000_0002;
    localparam logic [31:0] STEP_32BIT = 32'h0000_0004;

    typedef enum logic [1:0] {
        MODE_CONSTANT = 2'h0,
        MODE_POST_INC = 2'h1,
        MODE_SINGLE_INDEX = 2'h2,
        MODE_DOUBLE_INDEX = 2'h3
    } dag_mode_type;

    typedef enum logic [1:0] {
        DATA_8BIT = 2'h0,
        DATA_16BIT = 2'h1,
        DATA_32BIT = 2'h2
    } dag_data_type;

    // Working configuration handed over by the sequencer
    typedef struct packed {
        dag_data_type data_type;
        logic [15:0] src_element_step;
        logic [15:0] src_frame_step;
        logic [15:0] dest_element_step;
        logic [15:0] dest_frame_step;
    } dag_config_type;

    // Element-complete and start-load events from the sequencer
    typedef struct packed {
        logic element_done;
        logic last_in_frame;
        logic load_start;
    } dag_event_type;

endpackage

// [sim/dag_props.sv]
// Checker for the DMA address generator ports
`timescale 1ns/1ps
`default_nettype none
module dag_props (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Sequencer and addresses
    input wire dag_pkg::dag_config_type cfg,
    input wire dag_pkg::dag_event_type evt,
    input wire logic [31:0] src_addr,
    input wire logic [31:0] dest_addr
);
    logic [15:0] ctl_ff;
    logic sel_ff;
    logic ev;
    logic [31:0] exp_src;
    logic [31:0] exp_dst;
    function automatic logic [31:0] nx(logic [1:0] m, logic [31:0] a, logic [15:0] e, f);
        logic [15:0] ix;
        ix = (m == 2'h3 && evt.last_in_frame) ? f : e;
        // Post increment steps by the element size; an unused type code counts as bytes
        if (m == 2'h1) begin
            case (cfg.data_type)
                2'h1: return a + 32'h0000_0002;
                2'h2: return a + 32'h0000_0004;
                default: return a + 32'h0000_0001;
            endcase
        end
        return m == 2'h0 ? a : a + {{16{ix[15]}}, ix};
    endfunction
    assign ev = evt.element_done && !evt.load_start;
    always_comb exp_src = nx(ctl_ff[13:12], src_addr, cfg.src_element_step, cfg.src_frame_step);
    // Shared indexes come from the source fields when select is low
    always_comb exp_dst = nx(ctl_ff[15:14], dest_addr,
        sel_ff ? cfg.dest_element_step : cfg.src_element_step,
        sel_ff ? cfg.dest_frame_step : cfg.src_frame_step);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_ff <= 16'h0000;
            sel_ff <= 1'b0;
        end else if (reg_wr && reg_addr == dag_pkg::ADDR_CHANNEL_CONTROL) begin
            ctl_ff <= reg_wdata;
        end else if (reg_wr && reg_addr == dag_pkg::ADDR_INDEX_SELECT) begin
            sel_ff <= reg_wdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_SRC_STEP: assert property (ev |=> src_addr == $past(exp_src))
        else $error("source step wrong");
    AST_DST_STEP: assert property (ev |=> dest_addr == $past(exp_dst))
        else $error("destination step wrong");
    AST_SRC_CONST: assert property (ev && ctl_ff[13:12] == 2'h0 |=> $stable(src_addr))
        else $error("constant source moved");
    AST_IDLE_HOLD: assert property (!evt.element_done && !evt.load_start |=>
        $stable(src_addr) && $stable(dest_addr)) else $error("address moved without strobe");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not cleared");
    AST_RD_CTL: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(ctl_ff))
        else $error("control readback wrong");
    AST_RD_SRC: assert property (reg_rd && reg_addr == 4'h6 ##1 1'b1 |->
        reg_rdata == $past(src_addr[15:0])) else $error("source readback wrong");
    AST_RD_DST: assert property (reg_rd && reg_addr == 4'h9 |=>
        reg_rdata == $past(dest_addr[31:16])) else $error("destination readback wrong");
    cover property (ev && ctl_ff[15:14] == 2'h3 && evt.last_in_frame);
    cover property (evt.load_start);
    cover property (ev && sel_ff);
endmodule
bind dag_address_generator dag_props u_props (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cfg, .evt, .src_addr, .dest_addr);
`default_nettype wire

// [sim/dag_seq_model.sv]
// Sequencer model: start load, then element strobes with frame marks
`timescale 1ns/1ps
`default_nettype none
module dag_seq_model (
    // Clock, reset and bench control
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic slow,
    input wire logic [7:0] count,
    input wire logic [7:0] frame_len,
    // Events to the generator
    output var dag_pkg::dag_event_type evt,
    output logic busy
);
    logic [7:0] left_ff;
    logic [7:0] pos_ff;
    logic gap_ff;
    assign busy = left_ff != 8'h00;
    // Slow mode idles between strobes, as a stalled port would
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt <= '0;
            left_ff <= 8'h00;
            pos_ff <= 8'h00;
            gap_ff <= 1'b0;
        end else begin
            evt <= '0;
            gap_ff <= slow && !gap_ff;
            if (go) begin
                evt.load_start <= 1'b1;
                left_ff <= count;
                pos_ff <= 8'h00;
            end else if (busy && !gap_ff) begin
                evt.element_done <= 1'b1;
                evt.last_in_frame <= pos_ff == frame_len - 8'h01;
                pos_ff <= (pos_ff == frame_len - 8'h01) ? 8'h00 : pos_ff + 8'h01;
                left_ff <= left_ff - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/dag_address_generator_tb_top.sv]
// Bench for the DMA address generator
`timescale 1ns/1ps
`default_nettype none
module dag_address_generator_tb_top;
    localparam int N = 6;
    localparam int FL = 4;
    logic clk, rst_b, reg_wr, reg_rd, go, slow, busy;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, lo, hi;
    logic [31:0] src_addr, dest_addr, v;
    dag_pkg::dag_config_type cfg;
    dag_pkg::dag_event_type evt;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    dag_address_generator u_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cfg, .evt, .src_addr, .dest_addr);
    dag_seq_model u_seq (.clk, .rst_b, .go, .slow, .count(8'(N)), .frame_len(8'(FL)), .evt, .busy);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rd32(input logic [3:0] a);
        rd(a, lo);
        rd(a + 4'h1, hi);
        v = {hi, lo};
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [31:0] fin(logic [1:0] m, logic [31:0] a, st, e, f);
        case (m)
            2'h0: return a;
            2'h1: return a + N * st;
            2'h2: return a + N * e;
            default: return a + (N - N / FL) * e + (N / FL) * f;
        endcase
    endfunction
    initial begin
        {rst_b, reg_wr, reg_rd, go, slow, reg_addr, reg_wdata} = '0;
        cfg = {2'h0, 16'h0004, 16'hFFF8, 16'h0006, 16'h0020};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'hF, lo);
        chk({16'h0000, lo}, 32'h0000_0000);
        wr(dag_pkg::ADDR_SRC_START_LO, 16'h0100);
        wr(dag_pkg::ADDR_DST_START_HI, 16'h8000);
        for (int m = 0; m < 4; m++) begin
            for (int t = 0; t < 3; t++) begin
                wr(dag_pkg::ADDR_CHANNEL_CONTROL, {2'(3 - m), m[1:0], 12'h000});
                wr(dag_pkg::ADDR_INDEX_SELECT, {15'h0000, t[0]});
                rd(dag_pkg::ADDR_CHANNEL_CONTROL, lo);
                chk({16'h0000, lo}, {16'h0000, 2'(3 - m), m[1:0], 12'h000});
                cfg.data_type <= dag_pkg::dag_data_type'(t);
                slow <= t[0];
                go <= 1'b1;
                @(posedge clk);
                go <= 1'b0;
                repeat (2) @(posedge clk);
                for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
                repeat (2) @(posedge clk);
                rd32(dag_pkg::ADDR_SRC_NOW_LO);
                chk(v, fin(m[1:0], 32'h0000_0100, 32'h0000_0001 << t, 32'h0000_0004, 32'hFFFF_FFF8));
                rd32(dag_pkg::ADDR_DST_NOW_LO);
                chk(v, fin(2'(3 - m), 32'h8000_0000, 32'h0000_0001 << t, t[0] ? 32'h0000_0006 : 32'h0000_0004, t[0] ? 32'h0000_0020 : 32'hFFFF_FFF8));
                $display("test mode %0d type %0d done", m, t);
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
